// >>> hw/tla_defines.svh
// Purpose: named offsets, field positions and codes of the tx level block
// Assumes: 32-bit AXI4-Lite register words, byte addresses
// Notes: included by the package, the top module and the bench
`ifndef TLA_DEFINES_SVH
`define TLA_DEFINES_SVH
`define TLA_ADDR_W 8
`define TLA_NPHY 2
`define TLA_OFF_ADV0 8'h00
`define TLA_OFF_ADV1 8'h04
`define TLA_OFF_STAT0 8'h08
`define TLA_OFF_STAT1 8'h0C
`define TLA_OFF_IRQ_STAT 8'h10
`define TLA_OFF_IRQ_CLR 8'h14
`define TLA_OFF_IRQ_EN 8'h18
`define TLA_ADV_ABL 0
`define TLA_ADV_REQ 1
`define TLA_ADV_FORCE 4
`define TLA_ADV_RESTART 8
`define TLA_ADV_PREF 20
`define TLA_ADV_SRST 31
`define TLA_ST_DONE 0
`define TLA_ST_FAULT 1
`define TLA_ST_LP_ABL 2
`define TLA_ST_LP_REQ 3
`define TLA_ST_LP_FORCE 4
`define TLA_ST_LP_PREF 5
`define TLA_ST_TX_HI 6
`define TLA_ST_MASTER 7
`define TLA_ST_STRAP 8
`define TLA_IRQ_DONE 0
`define TLA_IRQ_FAULT 2
`define TLA_IRQ_W 4
`define TLA_RESP_OKAY 2'h0
`define TLA_RESP_SLVERR 2'h2
`define TLA_LFSR_SEED 16'hACE1
`define TLA_LFSR_TAPS 16'hB400
`endif

// >>> hw/tla_pkg.sv
// Purpose: types shared by the tx level advertisement block
// Assumes: tla_defines.svh gives the widths
// Notes: one advertisement record per phy
`include "tla_defines.svh"
package tla_pkg;
    typedef struct packed {
        logic ability;
        logic request;
        logic force_role;
        logic prefer_master;
    } tla_adv_t;

    typedef enum logic [1:0] {NEG_IDLE, NEG_RUN, NEG_DONE} tla_neg_t;

    typedef logic [`TLA_IRQ_W-1:0] tla_irq_t;
endpackage

// >>> hw/tla_adv_top.sv
// Purpose: tx level and role advertisement and resolution for two phys
// Assumes: page exchange hands over one partner record per page pulse
// Notes: registers over AXI4-Lite, one level interrupt output
`timescale 1ns/1ps
`default_nettype none
`include "tla_defines.svh"
module tla_adv_top import tla_pkg::*; #(
    parameter logic [`TLA_NPHY-1:0] DEF_PREF_MASTER = 2'h1
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [`TLA_ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [`TLA_ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic port1_high_swing_strap,
    input wire logic port2_high_swing_strap,
    input wire logic [`TLA_NPHY-1:0] partner_page_valid,
    input wire tla_adv_t [`TLA_NPHY-1:0] partner_adv,
    input wire logic [`TLA_NPHY-1:0] link_drop,
    output tla_adv_t [`TLA_NPHY-1:0] local_adv,
    output logic [`TLA_NPHY-1:0] negotiation_done_flag,
    output logic [`TLA_NPHY-1:0] config_fault,
    output logic [`TLA_NPHY-1:0] tx_high_level,
    output logic [`TLA_NPHY-1:0] role_master,
    output logic irq
);
    localparam int NPHY = `TLA_NPHY;

    function automatic logic resolve_level(input tla_adv_t l,
                                           input tla_adv_t p);
        resolve_level = l.ability & p.ability & (l.request | p.request);
    endfunction

    // returns {fault, master}
    function automatic logic [1:0] resolve_role(input tla_adv_t l,
                                                input tla_adv_t p,
                                                input logic rnd);
        if (l.force_role && p.force_role) begin
            resolve_role = {l.prefer_master == p.prefer_master,
                            l.prefer_master};
        end else if (l.force_role) begin
            resolve_role = {1'b0, l.prefer_master};
        end else if (p.force_role) begin
            resolve_role = {1'b0, ~p.prefer_master};
        end else if (l.prefer_master != p.prefer_master) begin
            resolve_role = {1'b0, l.prefer_master};
        end else begin
            resolve_role = {1'b0, rnd};
        end
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0] strb);
        merge = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                merge[b*8 +: 8] = data[b*8 +: 8];
            end
        end
    endfunction

    // ---------------- register state ----------------
    logic [NPHY-1:0] strap_ff, strap_taken_ff;
    logic [NPHY-1:0] abl_ff, req_ff, force_ff, pref_ff;
    tla_neg_t state_ff [NPHY];
    tla_adv_t [NPHY-1:0] partner_q;
    logic [NPHY-1:0] done_ff, fault_ff, tx_hi_ff, master_ff;
    tla_irq_t irq_stat_ff, irq_en_ff, nxt_irq_stat;
    logic [15:0] lfsr_ff;

    // ---------------- AXI write path ----------------
    logic aw_got_ff, w_got_ff, bvalid_ff;
    logic [`TLA_ADDR_W-1:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic [1:0] bresp_ff;
    logic aw_hs, w_hs, wr_fire;
    logic [`TLA_ADDR_W-1:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_hit;

    assign awready = ~aw_got_ff & ~bvalid_ff;
    assign wready = ~w_got_ff & ~bvalid_ff;
    assign aw_hs = awvalid & awready;
    assign w_hs = wvalid & wready;
    assign wr_fire = (aw_got_ff | aw_hs) & (w_got_ff | w_hs) & ~bvalid_ff;
    assign wr_addr = aw_got_ff ? awaddr_ff : awaddr;
    assign wr_data = w_got_ff ? wdata_ff : wdata;
    assign wr_strb = w_got_ff ? wstrb_ff : wstrb;

    logic [NPHY-1:0] wr_adv, sw_restart, soft_rst, restart_req;
    logic [31:0] adv_word [NPHY];
    logic [31:0] adv_new [NPHY];
    logic wr_irq_clr, wr_irq_en;
    logic [31:0] irq_clr_word, irq_en_word;

    assign wr_adv[0] = wr_fire & (wr_addr == `TLA_OFF_ADV0);
    assign wr_adv[1] = wr_fire & (wr_addr == `TLA_OFF_ADV1);
    assign wr_irq_clr = wr_fire & (wr_addr == `TLA_OFF_IRQ_CLR);
    assign wr_irq_en = wr_fire & (wr_addr == `TLA_OFF_IRQ_EN);
    assign irq_clr_word = merge(32'h0, wr_data, wr_strb);
    assign irq_en_word = merge({28'h0, irq_en_ff}, wr_data, wr_strb);
    assign wr_hit = (wr_addr == `TLA_OFF_ADV0) | (wr_addr == `TLA_OFF_ADV1) |
                    (wr_addr == `TLA_OFF_IRQ_CLR) |
                    (wr_addr == `TLA_OFF_IRQ_EN);

    // self-clearing action bits read as zero, so merge never repeats them
    always_comb begin
        for (int i = 0; i < NPHY; i++) begin
            adv_word[i] = 32'h0;
            adv_word[i][`TLA_ADV_ABL] = abl_ff[i];
            adv_word[i][`TLA_ADV_REQ] = req_ff[i];
            adv_word[i][`TLA_ADV_FORCE] = force_ff[i];
            adv_word[i][`TLA_ADV_PREF] = pref_ff[i];
            adv_new[i] = merge(adv_word[i], wr_data, wr_strb);
            sw_restart[i] = wr_adv[i] & adv_new[i][`TLA_ADV_RESTART];
            soft_rst[i] = wr_adv[i] & adv_new[i][`TLA_ADV_SRST];
            restart_req[i] = sw_restart[i] | link_drop[i];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= `TLA_RESP_OKAY;
            awaddr_ff <= '0;
            wdata_ff <= 32'h0;
            wstrb_ff <= 4'h0;
        end else begin
            if (aw_hs) awaddr_ff <= awaddr;
            if (w_hs) wdata_ff <= wdata;
            if (w_hs) wstrb_ff <= wstrb;
            if (wr_fire) begin
                aw_got_ff <= 1'b0;
                w_got_ff <= 1'b0;
                bvalid_ff <= 1'b1;
                bresp_ff <= wr_hit ? `TLA_RESP_OKAY : `TLA_RESP_SLVERR;
            end else begin
                aw_got_ff <= aw_got_ff | aw_hs;
                w_got_ff <= w_got_ff | w_hs;
                if (bvalid_ff && bready) bvalid_ff <= 1'b0;
            end
        end
    end
    assign bvalid = bvalid_ff;
    assign bresp = bresp_ff;

    // ---------------- advertisement registers ----------------
    // strap is sampled once, in the first cycle after reset release
    logic [NPHY-1:0] strap_pins;
    assign strap_pins = {port2_high_swing_strap, port1_high_swing_strap};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            strap_ff <= '0;
            strap_taken_ff <= '0;
            abl_ff <= '0;
            req_ff <= '0;
            force_ff <= '0;
            pref_ff <= DEF_PREF_MASTER;
        end else begin
            for (int i = 0; i < NPHY; i++) begin
                if (!strap_taken_ff[i]) begin
                    strap_taken_ff[i] <= 1'b1;
                    strap_ff[i] <= strap_pins[i];
                    abl_ff[i] <= strap_pins[i];
                end else if (soft_rst[i]) begin
                    abl_ff[i] <= strap_ff[i];
                    req_ff[i] <= 1'b0;
                    force_ff[i] <= 1'b0;
                    pref_ff[i] <= DEF_PREF_MASTER[i];
                end else if (wr_adv[i]) begin
                    if (strap_ff[i]) begin
                        abl_ff[i] <= adv_new[i][`TLA_ADV_ABL];
                        req_ff[i] <= adv_new[i][`TLA_ADV_REQ];
                    end
                    force_ff[i] <= adv_new[i][`TLA_ADV_FORCE];
                    pref_ff[i] <= adv_new[i][`TLA_ADV_PREF];
                end
            end
        end
    end

    // an unstrapped port can never offer the high swing
    always_comb begin
        for (int i = 0; i < NPHY; i++) begin
            local_adv[i].ability = abl_ff[i] & strap_ff[i];
            local_adv[i].request = req_ff[i] & strap_ff[i];
            local_adv[i].force_role = force_ff[i];
            local_adv[i].prefer_master = pref_ff[i];
        end
    end

    // ---------------- negotiation and resolution ----------------
    logic [NPHY-1:0] res_level, res_fault, res_master;
    logic [NPHY-1:0] done_evt, fault_evt;

    always_comb begin
        for (int i = 0; i < NPHY; i++) begin
            res_level[i] = resolve_level(local_adv[i],
                                         partner_adv[i]);
            {res_fault[i], res_master[i]} =
                resolve_role(local_adv[i], partner_adv[i],
                             lfsr_ff[i]);
            done_evt[i] = (state_ff[i] == NEG_RUN) & partner_page_valid[i] &
                          ~restart_req[i] & ~res_fault[i];
            fault_evt[i] = (state_ff[i] == NEG_RUN) & partner_page_valid[i] &
                           ~restart_req[i] & res_fault[i];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lfsr_ff <= `TLA_LFSR_SEED;
        end else begin
            lfsr_ff <= (lfsr_ff >> 1) ^ ({16{lfsr_ff[0]}} & `TLA_LFSR_TAPS);
        end
    end

    always_ff @(posedge aclk) begin
        for (int i = 0; i < NPHY; i++) begin
            if (!aresetn || soft_rst[i]) begin
                state_ff[i] <= NEG_IDLE;
                partner_q[i] <= '0;
                done_ff[i] <= 1'b0;
                fault_ff[i] <= 1'b0;
                tx_hi_ff[i] <= 1'b0;
                master_ff[i] <= 1'b0;
            end else begin
                case (state_ff[i])
                    NEG_IDLE: begin
                        state_ff[i] <= NEG_RUN;
                    end
                    NEG_RUN: begin
                        if (restart_req[i]) begin
                            state_ff[i] <= NEG_IDLE;
                        end else if (partner_page_valid[i]) begin
                            partner_q[i] <= partner_adv[i];
                            fault_ff[i] <= res_fault[i];
                            if (!res_fault[i]) begin
                                state_ff[i] <= NEG_DONE;
                                done_ff[i] <= 1'b1;
                                tx_hi_ff[i] <= res_level[i];
                                master_ff[i] <= res_master[i];
                            end
                        end
                    end
                    NEG_DONE: begin
                        if (restart_req[i]) begin
                            state_ff[i] <= NEG_IDLE;
                            done_ff[i] <= 1'b0;
                            tx_hi_ff[i] <= 1'b0;
                        end
                    end
                    default: state_ff[i] <= NEG_IDLE;
                endcase
            end
        end
    end

    assign negotiation_done_flag = done_ff;
    assign config_fault = fault_ff;
    assign tx_high_level = tx_hi_ff;
    assign role_master = master_ff;

    // ---------------- interrupts ----------------
    // a new event wins over a clear written in the same cycle
    assign nxt_irq_stat = (irq_stat_ff &
                           ~(wr_irq_clr ? irq_clr_word[`TLA_IRQ_W-1:0]
                                        : 4'h0)) |
                          {fault_evt, done_evt};
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat_ff <= '0;
            irq_en_ff <= '0;
        end else begin
            irq_stat_ff <= nxt_irq_stat;
            if (wr_irq_en) irq_en_ff <= irq_en_word[`TLA_IRQ_W-1:0];
        end
    end
    assign irq = |(irq_stat_ff & irq_en_ff);

    // ---------------- AXI read path ----------------
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;
    logic ar_hs, rd_hit;
    logic [31:0] stat_word [NPHY];
    logic [31:0] rd_word;

    always_comb begin
        for (int i = 0; i < NPHY; i++) begin
            stat_word[i] = 32'h0;
            stat_word[i][`TLA_ST_DONE] = done_ff[i];
            stat_word[i][`TLA_ST_FAULT] = fault_ff[i];
            stat_word[i][`TLA_ST_LP_ABL] = partner_q[i].ability;
            stat_word[i][`TLA_ST_LP_REQ] = partner_q[i].request;
            stat_word[i][`TLA_ST_LP_FORCE] = partner_q[i].force_role;
            stat_word[i][`TLA_ST_LP_PREF] = partner_q[i].prefer_master;
            stat_word[i][`TLA_ST_TX_HI] = tx_hi_ff[i];
            stat_word[i][`TLA_ST_MASTER] = master_ff[i];
            stat_word[i][`TLA_ST_STRAP] = strap_ff[i];
        end
    end

    assign arready = ~rvalid_ff;
    assign ar_hs = arvalid & arready;
    assign rd_word = (araddr == `TLA_OFF_ADV0) ? adv_word[0] :
                     (araddr == `TLA_OFF_ADV1) ? adv_word[1] :
                     (araddr == `TLA_OFF_STAT0) ? stat_word[0] :
                     (araddr == `TLA_OFF_STAT1) ? stat_word[1] :
                     (araddr == `TLA_OFF_IRQ_STAT) ? {28'h0, irq_stat_ff} :
                     (araddr == `TLA_OFF_IRQ_EN) ? {28'h0, irq_en_ff} :
                     32'h0;
    assign rd_hit = (araddr == `TLA_OFF_ADV0) | (araddr == `TLA_OFF_ADV1) |
                    (araddr == `TLA_OFF_STAT0) | (araddr == `TLA_OFF_STAT1) |
                    (araddr == `TLA_OFF_IRQ_STAT) |
                    (araddr == `TLA_OFF_IRQ_CLR) |
                    (araddr == `TLA_OFF_IRQ_EN);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0;
            rresp_ff <= `TLA_RESP_OKAY;
        end else if (ar_hs) begin
            rvalid_ff <= 1'b1;
            rdata_ff <= rd_word;
            rresp_ff <= rd_hit ? `TLA_RESP_OKAY : `TLA_RESP_SLVERR;
        end else if (rready) begin
            rvalid_ff <= 1'b0;
        end
    end
    assign rvalid = rvalid_ff;
    assign rdata = rdata_ff;
    assign rresp = rresp_ff;

    // ---------------- assertions ----------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_strap_gate: assert property (
        !strap_ff[1] |-> !local_adv[1].ability && !local_adv[1].request)
        else $error("high level advertised without strap");
    a_partner_hold: assert property (
        done_ff[0] && $past(done_ff[0]) |-> $stable(partner_q[0]))
        else $error("partner bits changed while done");
    a_low_level: assert property (
        $rose(done_ff[0]) && !partner_q[0].ability |-> !tx_hi_ff[0])
        else $error("high level without partner ability");
    a_high_level: assert property (
        $rose(done_ff[0]) |-> tx_hi_ff[0] ==
        ($past(local_adv[0].ability) && partner_q[0].ability &&
         ($past(local_adv[0].request) || partner_q[0].request)))
        else $error("resolved level mismatch");
    a_write_gate: assert property (
        wr_adv[1] && !soft_rst[1] && !strap_ff[1] && strap_taken_ff[1]
        |=> $stable(abl_ff[1]) && $stable(req_ff[1]))
        else $error("ability write took effect unstrapped");
    a_abl_clear: assert property (
        $rose(done_ff[0]) && !$past(local_adv[0].ability) |-> !tx_hi_ff[0])
        else $error("high level with local ability clear");
    a_pref_default: assert property (
        $rose(aresetn) |-> pref_ff == DEF_PREF_MASTER)
        else $error("role preference not at default");
    a_force_wins: assert property (
        $rose(done_ff[0]) && $past(local_adv[0].force_role) &&
        !partner_q[0].force_role |->
        master_ff[0] == $past(local_adv[0].prefer_master))
        else $error("forced role not honoured");
    a_fault_retry: assert property (
        fault_evt[0] |=> fault_ff[0] && !done_ff[0] &&
        state_ff[0] == NEG_RUN)
        else $error("fault did not keep negotiation running");
    a_amp_hold: assert property (
        done_ff[1] && $past(done_ff[1]) |-> $stable(tx_hi_ff[1]))
        else $error("amplitude changed while done");

    c_high_done: cover property ($rose(done_ff[0]) && tx_hi_ff[0]);
    c_fault: cover property (fault_evt[1]);
    c_write: cover property (bvalid_ff && bready);
    c_irq: cover property ($rose(irq));
endmodule
`default_nettype wire

// >>> verification/tla_lp_model.sv
// Purpose: remote link partner page source for one phy
// Assumes: one record per send request, delivered lag+1 cycles after send is sampled
// Notes: record lines toggle outside the page pulse
`timescale 1ns/1ps
`default_nettype none
module tla_lp_model import tla_pkg::*; (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic send,
    input wire tla_adv_t rec,
    input wire logic [2:0] lag,
    output logic page_valid,
    output tla_adv_t adv,
    output logic busy
);
    logic [2:0] cnt_ff;
    tla_adv_t hold_ff;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_ff <= 3'h0;
            busy <= 1'b0;
            page_valid <= 1'b0;
            adv <= 4'h0;
        end else if (busy && cnt_ff == 3'h0) begin
            busy <= 1'b0;
            page_valid <= 1'b1;
            adv <= hold_ff;
        end else begin
            // a stale record would hide a late sample, so it keeps moving
            page_valid <= 1'b0;
            adv <= ~adv;
            busy <= busy | send;
            cnt_ff <= send ? lag : cnt_ff - 3'h1;
            if (send) hold_ff <= rec;
        end
    end
endmodule
`default_nettype wire

// >>> verification/tx_level_role_advertisement_tb.sv
// Purpose: self-checking bench for the tx level and role block
// Assumes: port1 strapped for high swing, port2 not
// Notes: reads and write responses are checked by a queue monitor
`timescale 1ns/1ps
`default_nettype none
`include "tla_defines.svh"
module tx_level_role_advertisement_tb import tla_pkg::*;;
    typedef struct packed {
        logic [31:0] d;
        logic [31:0] m;
        logic [1:0] r;
    } tla_exp_t;
    localparam logic [1:0] ok = `TLA_RESP_OKAY;
    localparam logic [1:0] se = `TLA_RESP_SLVERR;
    localparam logic [31:0] full = 32'hFFFFFFFF;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [1:0] send = 2'h0, link_drop = 2'h0;
    logic [2:0] lag = 3'h0;
    tla_adv_t rec = 4'h0;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp, pv, busy, done, fault, txh, rolem;
    logic [31:0] rdata, w, sm;
    tla_adv_t [1:0] padv, ladv;
    logic la, lr, lf, lp, pa, pr, pf, pp, flt, tie, mst, txe;
    tla_exp_t rq[$];
    tla_exp_t e;
    logic [1:0] bq[$];
    int fails = 0;
    int samples_checked = 0;

    always #5 aclk = ~aclk;

    tla_adv_top uut (
        .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hF),
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
        .arready, .rdata, .rresp, .rvalid, .rready,
        .port1_high_swing_strap(1'b1), .port2_high_swing_strap(1'b0),
        .partner_page_valid(pv), .partner_adv(padv), .link_drop,
        .local_adv(ladv), .negotiation_done_flag(done), .config_fault(fault),
        .tx_high_level(txh), .role_master(rolem), .irq
    );
    tla_lp_model lp0 (.aclk, .aresetn, .send(send[0]), .rec, .lag,
        .page_valid(pv[0]), .adv(padv[0]), .busy(busy[0]));
    tla_lp_model lp1 (.aclk, .aresetn, .send(send[1]), .rec, .lag,
        .page_valid(pv[1]), .adv(padv[1]), .busy(busy[1]));

    task automatic chk(input string n, input logic [31:0] x,
                       input logic [31:0] g);
        samples_checked++;
        if (g !== x) begin
            fails++;
            $display("mismatch %s expected %h seen %h", n, x, g);
        end
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic tmo(input int n);
        if (n >= 60) begin
            fails++;
            $display("mismatch handshake expected answer seen timeout");
            close_out();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] r);
        int n;
        @(posedge aclk);
        bq.push_back(r);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            n++;
        end while (!bvalid && n < 60);
        bready <= 1'b0;
        tmo(n);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] d,
                      input logic [31:0] m, input logic [1:0] r);
        int n;
        @(posedge aclk);
        rq.push_back({d, m, r});
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            n++;
        end while (!rvalid && n < 60);
        rready <= 1'b0;
        tmo(n);
    endtask

    // page lands on the edge busy drops, results one edge later
    task automatic pg(input int i, input tla_adv_t v);
        int n;
        @(posedge aclk);
        rec <= v;
        lag <= 3'($urandom % 8);
        send[i] <= 1'b1;
        @(posedge aclk);
        send[i] <= 1'b0;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
        end while (busy[i] !== 1'b0 && n < 60);
        @(posedge aclk);
        tmo(n);
    endtask

    always @(posedge aclk) begin
        if (aresetn && rvalid && rready && rq.size() > 0) begin
            e = rq.pop_front();
            chk("rdata", e.d, rdata & e.m);
            chk("rresp", {30'h0, e.r}, {30'h0, rresp});
        end
        if (aresetn && bvalid && bready && bq.size() > 0)
            chk("bresp", {30'h0, bq.pop_front()}, {30'h0, bresp});
    end

    initial begin
        void'($urandom(29));
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(`TLA_OFF_ADV0, 32'h00100001, full, ok);
        rd(`TLA_OFF_ADV1, 32'h0, full, ok);
        wr(`TLA_OFF_ADV1, 32'h3, ok);
        rd(`TLA_OFF_ADV1, 32'h0, full, ok);
        chk("ability2", 32'h0, 32'(ladv[1].ability));
        pg(1, 4'hF);
        chk("tx2", 32'h0, 32'(txh[1]));
        rd(8'h40, 32'h0, full, se);
        wr(8'h40, 32'h1, se);
        wr(`TLA_OFF_STAT0, 32'h1, se);
        rd(`TLA_OFF_IRQ_CLR, 32'h0, full, ok);
        $display("test straps and map done");
        for (int k = 0; k < 256; k++) begin
            {la, lr, lf, lp, pa, pr, pf, pp} = k[7:0];
            w = (32'(lp) << 20) | (32'(lf) << 4) | (32'(lr) << 1) | 32'(la);
            wr(`TLA_OFF_ADV0, w | 32'h100, ok);
            rd(`TLA_OFF_ADV0, w, full, ok);
            pg(0, {pa, pr, pf, pp});
            flt = lf & pf & (lp == pp);
            tie = !lf & !pf & (lp == pp);
            mst = lf ? lp : (pf ? !pp : lp);
            txe = la & pa & (lr | pr) & !flt;
            chk("fault", 32'(flt), 32'(fault[0]));
            chk("done", 32'(!flt), 32'(done[0]));
            if (!flt) chk("tx", 32'(txe), 32'(txh[0]));
            if (!flt && !tie) chk("role", 32'(mst), 32'(rolem[0]));
            sm = flt ? 32'h103 : (tie ? 32'h17F : 32'h1FF);
            rd(`TLA_OFF_STAT0, {23'h1, mst, txe, pp, pf, pr, pa, flt, !flt}
               & sm, sm, ok);
            if (!flt) begin
                pg(0, ~{pa, pr, pf, pp});
                chk("held", 32'(txe), 32'(txh[0]));
            end
        end
        $display("test resolution table done");
        wr(`TLA_OFF_IRQ_CLR, 32'hF, ok);
        wr(`TLA_OFF_IRQ_EN, 32'h1, ok);
        rd(`TLA_OFF_IRQ_EN, 32'h1, full, ok);
        wr(`TLA_OFF_ADV0, 32'h00100103, ok);
        pg(0, 4'hC);
        chk("irq", 32'h1, 32'(irq));
        rd(`TLA_OFF_IRQ_STAT, 32'h1, full, ok);
        @(posedge aclk);
        link_drop[0] <= 1'b1;
        @(posedge aclk);
        link_drop[0] <= 1'b0;
        repeat (2) @(posedge aclk);
        chk("drop_done", 32'h0, 32'(done[0]));
        chk("drop_tx", 32'h0, 32'(txh[0]));
        wr(`TLA_OFF_IRQ_EN, 32'h0, ok);
        chk("irq_masked", 32'h0, 32'(irq));
        wr(`TLA_OFF_IRQ_EN, 32'h1, ok);
        chk("irq_unmasked", 32'h1, 32'(irq));
        wr(`TLA_OFF_IRQ_CLR, 32'h1, ok);
        chk("irq_cleared", 32'h0, 32'(irq));
        wr(`TLA_OFF_ADV0, 32'h00100113, ok);
        pg(0, 4'h3);
        rd(`TLA_OFF_IRQ_STAT, 32'h4, 32'h4, ok);
        wr(`TLA_OFF_ADV0, 32'h80000000, ok);
        rd(`TLA_OFF_ADV0, 32'h00100001, full, ok);
        chk("srst_fault", 32'h0, 32'(fault[0]));
        $display("test interrupts and restart done");
        close_out();
    end
endmodule
`default_nettype wire
